//--- bhc_axi_pair.sv
// Read slave model that answers requests after a set delay and returns their beats.
`timescale 1ns/1ps
////////////////////////
module bhc_axi_pair (
    input wire logic clk,
    input wire logic aresetn,
    input wire logic ar_valid,
    input wire bhc_pkg::bhc_ar_t ar,
    input wire logic r_ready,
    input wire logic [3:0] lat,
    input wire logic shrt,
    output logic ar_ready,
    output logic r_valid,
    output logic [3:0] r_id,
    output logic r_last
);
    logic [3:0] cnt;
    logic [7:0] left;
    // One burst at a time; a short burst ends one beat early on purpose.
    always_ff @(posedge clk) begin
        ar_ready <= 1'b0;
        if (!aresetn) begin
            cnt <= 4'h0;
            r_valid <= 1'b0;
            r_last <= 1'b0;
            r_id <= 4'h0;
            left <= 8'h00;
        end else if (r_valid) begin
            if (r_ready) begin
                r_valid <= left != 8'h00;
                r_last <= left == 8'h01;
                left <= left - 8'h01;
                r_id <= (left == 8'h00) ? ~r_id : r_id;
            end
        end else if (ar_valid && ar_ready) begin
            r_valid <= 1'b1;
            r_id <= ar.id;
            left <= ar.len - {7'h00, shrt};
            r_last <= ar.len == {7'h00, shrt};
        end else if (!ar_valid) begin
            cnt <= 4'h0;
        end else if (cnt == lat) begin
            ar_ready <= 1'b1;
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

//--- bhc_checker.sv
// Passive AXI handshake monitor with sticky flags and an APB status port.
// Notes on behaviour
// - Bit 27: write-data valid fell before ready was seen.
// - Bit 28: write-data ready later than the wait limit.
// - Bit 29: response valid rose before the last write beat; not Lite.
// - Bit 31: response valid high in the first cycle after reset.
// - Bit 32: response valid rose before its write address handshake.
// - Bits 33 and 34: response ID or code changed while stalled.
// - Bit 35: response valid fell before ready was seen.
// - Bit 36: response ready later than the wait limit.
// - Bit 37: incrementing read burst crosses a 4KB page.
// - Bit 38: wrapping read start not size aligned.
// - Bit 39: reserved read burst type while valid.
// - Bit 41: cache bit 1 low but bit 3 or 2 high.
// - Bit 42: fixed read burst longer than 16 beats.
// - Bit 43: wrapping read beat count not 2, 4, 8 or 16.
// - Bit 44: read beat size wider than the data bus.
// - Bit 45: read address valid high in the first cycle after reset.
// - Bits 46 to 50 and 52 to 55: stalled read address attribute changed.
// - Bit 56: read address valid fell before ready.
// - Bit 57: read address ready later than the wait limit.
// - Bit 58: read beat count differs from requested length.
// - Bit 59: read data with no outstanding request of its ID.
// - Bits 30, 40, 51 and 60 never rise.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
////////////////////////
module bhc_wait_watch (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic aresetn,
    input wire logic valid,
    input wire logic ready,
    input wire logic [15:0] limit,
    output logic drop,
    output logic slow
);
    logic pend;
    logic [15:0] cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend <= 1'b0;
        end else begin
            pend <= aresetn & valid & !ready;
        end
    end

    // The counter saturates so a stuck channel cannot wrap and hide.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 16'h0000;
        end else if (!aresetn || !valid || ready) begin
            cnt <= 16'h0000;
        end else if (cnt != 16'hFFFF) begin
            cnt <= cnt + 16'h0001;
        end
    end

    assign drop = aresetn & pend & !valid;
    assign slow = aresetn & valid & !ready & (cnt >= limit);
endmodule
////////////////////////
module bhc_checker #(
    parameter int DATA_W = 32,
    parameter int RD_DEPTH = 8,
    parameter logic [15:0] MAX_WAIT = bhc_pkg::WAIT_RST
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic aresetn,
    input wire logic aw_valid,
    input wire logic aw_ready,
    input wire logic w_valid,
    input wire logic w_ready,
    input wire logic w_last,
    input wire logic b_valid,
    input wire logic b_ready,
    input wire logic [bhc_pkg::ID_W-1:0] b_id,
    input wire logic [1:0] b_resp,
    input wire logic ar_valid,
    input wire logic ar_ready,
    input wire bhc_pkg::bhc_ar_t ar,
    input wire logic r_valid,
    input wire logic r_ready,
    input wire logic [bhc_pkg::ID_W-1:0] r_id,
    input wire logic r_last,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [63:0] status
);
    localparam logic [2:0] SIZE_MAX = 3'($clog2(DATA_W / 8));
    localparam int IDX_W = $clog2(RD_DEPTH);

    logic rst_meta, rst_n, not_lite, last_aresetn, first_cycle;
    logic [15:0] max_wait_cycles;
    bhc_pkg::bhc_proto_t mode;
    logic [63:0] hit;
    ////////////////////
    // Reset release through two flip-flops.

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////
    // APB slave; read data is prepared in the setup cycle, so no wait states.
    logic acc, mapped;
    logic [11:0] ofs;

    assign acc = psel & penable;
    assign ofs = paddr[11:0];
    assign pready = 1'b1;
    assign mapped = (paddr[31:12] == 20'h0_0000) && (ofs == bhc_pkg::OFS_WAIT || ofs == bhc_pkg::OFS_MODE
        || ofs == bhc_pkg::OFS_STAT_LO || ofs == bhc_pkg::OFS_STAT_HI);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            max_wait_cycles <= MAX_WAIT;
            mode <= bhc_pkg::MODE_RST;
        end else if (acc && pwrite && paddr[31:12] == 20'h0_0000) begin
            if (ofs == bhc_pkg::OFS_WAIT) begin
                max_wait_cycles <= pwdata[15:0];
            end
            if (ofs == bhc_pkg::OFS_MODE && pwdata[1:0] != 2'b11) begin
                mode <= bhc_pkg::bhc_proto_t'(pwdata[1:0]);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !mapped;
            prdata <= 32'h0000_0000;
            if (!pwrite) begin
                unique case (ofs)
                    bhc_pkg::OFS_WAIT: prdata <= {16'h0000, max_wait_cycles};
                    bhc_pkg::OFS_MODE: prdata <= {30'h0000_0000, mode};
                    bhc_pkg::OFS_STAT_LO: prdata <= status[31:0];
                    bhc_pkg::OFS_STAT_HI: prdata <= status[63:32];
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign not_lite = (mode != bhc_pkg::BHC_LITE);

    ////////////////////
    // First cycle after the interface reset goes high.

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_aresetn <= 1'b0;
        end else begin
            last_aresetn <= aresetn;
        end
    end

    assign first_cycle = aresetn & !last_aresetn;

    ////////////////////
    // Valid hold and ready delay watchers.
    logic w_drop, w_slow, b_drop, b_slow, ar_drop, ar_slow;

    bhc_wait_watch u_w_watch (.clk(clk), .rst_n(rst_n), .aresetn(aresetn), .valid(w_valid), .ready(w_ready),
        .limit(max_wait_cycles), .drop(w_drop), .slow(w_slow));

    bhc_wait_watch u_b_watch (.clk(clk), .rst_n(rst_n), .aresetn(aresetn), .valid(b_valid), .ready(b_ready),
        .limit(max_wait_cycles), .drop(b_drop), .slow(b_slow));

    bhc_wait_watch u_ar_watch (.clk(clk), .rst_n(rst_n), .aresetn(aresetn), .valid(ar_valid), .ready(ar_ready),
        .limit(max_wait_cycles), .drop(ar_drop), .slow(ar_slow));

    ////////////////////
    // Write response ordering.
    logic [7:0] aw_open, wl_open;
    logic b_wait, b_start, b_hs;
    logic [bhc_pkg::ID_W-1:0] b_id_q;
    logic [1:0] b_resp_q;

    assign b_hs = b_valid & b_ready;
    assign b_start = aresetn & b_valid & !b_wait;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_open <= 8'h00;
            wl_open <= 8'h00;
        end else if (!aresetn) begin
            aw_open <= 8'h00;
            wl_open <= 8'h00;
        end else begin
            aw_open <= aw_open + 8'(aw_valid & aw_ready) - 8'(b_hs && aw_open != 8'h00);
            wl_open <= wl_open + 8'(w_valid & w_ready & w_last) - 8'(b_hs && wl_open != 8'h00);
        end
    end

    // Payload is captured every stalled cycle so any change is seen next cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            b_wait <= 1'b0;
            b_id_q <= '0;
            b_resp_q <= 2'b00;
        end else begin
            b_wait <= aresetn & b_valid & !b_ready;
            b_id_q <= b_id;
            b_resp_q <= b_resp;
        end
    end

    ////////////////////
    // Read address legality.
    logic [8:0] beats;
    logic [16:0] span;
    logic [11:0] align;
    logic ar_wait;
    bhc_pkg::bhc_ar_t ar_q;
    logic ar_held;

    assign beats = {1'b0, ar.len} + 9'h001;
    assign span = 17'(ar.addr[11:0]) + (17'(beats) << ar.size);
    assign align = (12'h001 << ar.size) - 12'h001;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ar_wait <= 1'b0;
            ar_q <= '0;
        end else begin
            ar_wait <= aresetn & ar_valid & !ar_ready;
            ar_q <= ar;
        end
    end

    assign ar_held = ar_wait & ar_valid;

    ////////////////////
    // Outstanding read table; an ID is matched to the lowest used entry.
    logic [RD_DEPTH-1:0] rd_used;
    logic [bhc_pkg::ID_W-1:0] rd_tag [RD_DEPTH];
    logic [8:0] rd_left [RD_DEPTH];
    logic [IDX_W-1:0] free_idx, hit_idx;
    logic free_ok, hit_ok, r_wait, r_start, r_hs, r_end;

    always_comb begin
        free_idx = '0;
        free_ok = 1'b0;
        hit_idx = '0;
        hit_ok = 1'b0;
        for (int i = RD_DEPTH - 1; i >= 0; i--) begin
            if (!rd_used[i]) begin
                free_idx = IDX_W'(i);
                free_ok = 1'b1;
            end
            if (rd_used[i] && rd_tag[i] == r_id) begin
                hit_idx = IDX_W'(i);
                hit_ok = 1'b1;
            end
        end
    end

    assign r_hs = aresetn & r_valid & r_ready;
    assign r_start = aresetn & r_valid & !r_wait;
    // Lite has no last-beat signal; every beat closes its request.
    assign r_end = not_lite ? r_last : 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_wait <= 1'b0;
        end else begin
            r_wait <= aresetn & r_valid & !r_ready;
        end
    end

    // A full table drops new requests; later beats for them then look orphaned.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_used <= '0;
            for (int i = 0; i < RD_DEPTH; i++) begin
                rd_tag[i] <= '0;
                rd_left[i] <= 9'h000;
            end
        end else if (!aresetn) begin
            rd_used <= '0;
        end else begin
            if (r_hs && hit_ok) begin
                rd_left[hit_idx] <= rd_left[hit_idx] - 9'h001;
                if (r_end) begin
                    rd_used[hit_idx] <= 1'b0;
                end
            end
            if (ar_valid && ar_ready && free_ok) begin
                rd_used[free_idx] <= 1'b1;
                rd_tag[free_idx] <= ar.id;
                rd_left[free_idx] <= not_lite ? beats : 9'h001;
            end
        end
    end

    ////////////////////
    // Violation detection.
    always_comb begin
        hit = 64'h0000_0000_0000_0000;
        hit[bhc_pkg::WR_DATA_VALID_HOLD_CHECK] = w_drop;
        hit[bhc_pkg::WR_DATA_READY_DELAY_ADVICE] = w_slow;
        hit[bhc_pkg::RESP_BEFORE_LAST_BEAT_CHECK] = b_start && not_lite && wl_open == 8'h00;
        hit[bhc_pkg::RESP_VALID_AFTER_RESET_CHECK] = first_cycle & b_valid;
        hit[bhc_pkg::RESP_BEFORE_ADDR_CHECK] = b_start && aw_open == 8'h00;
        hit[bhc_pkg::RESP_ID_HOLD_CHECK] = b_wait && b_valid && not_lite && b_id != b_id_q;
        hit[bhc_pkg::RESP_CODE_HOLD_CHECK] = b_wait && b_valid && b_resp != b_resp_q;
        hit[bhc_pkg::RESP_VALID_HOLD_CHECK] = b_drop;
        hit[bhc_pkg::RESP_READY_DELAY_ADVICE] = b_slow;
        if (aresetn && ar_valid && not_lite) begin
            hit[bhc_pkg::RD_PAGE_CROSS_CHECK] = (ar.burst != bhc_pkg::BURST_FIXED)
                && (ar.burst != bhc_pkg::BURST_WRAP) && span > bhc_pkg::PAGE_BYTES;
            hit[bhc_pkg::RD_WRAP_ALIGN_CHECK] = ar.burst == bhc_pkg::BURST_WRAP
                && (ar.addr[11:0] & align) != 12'h000;
            hit[bhc_pkg::RD_BURST_RESERVED_CHECK] = ar.burst == bhc_pkg::BURST_RSVD;
            hit[bhc_pkg::RD_CACHE_COMBO_CHECK] = !ar.cache[1] && ar.cache[3:2] != 2'b00;
            hit[bhc_pkg::RD_FIXED_LEN_CHECK] = ar.burst == bhc_pkg::BURST_FIXED
                && ar.len > bhc_pkg::FIXED_LEN_MAX;
            hit[bhc_pkg::RD_WRAP_LEN_CHECK] = ar.burst == bhc_pkg::BURST_WRAP && beats != 9'h002
                && beats != 9'h004 && beats != 9'h008 && beats != 9'h010;
            hit[bhc_pkg::RD_BEAT_WIDTH_CHECK] = ar.size > SIZE_MAX;
        end
        hit[bhc_pkg::RD_ADDR_VALID_AFTER_RESET_CHECK] = first_cycle & ar_valid;
        if (ar_held) begin
            hit[bhc_pkg::RD_ADDR_HOLD_CHECK] = ar.addr != ar_q.addr;
            hit[bhc_pkg::RD_PROT_HOLD_CHECK] = ar.prot != ar_q.prot;
            if (not_lite) begin
                hit[bhc_pkg::RD_BURST_TYPE_HOLD_CHECK] = ar.burst != ar_q.burst;
                hit[bhc_pkg::RD_CACHE_HOLD_CHECK] = ar.cache != ar_q.cache;
                hit[bhc_pkg::RD_TAG_HOLD_CHECK] = ar.id != ar_q.id;
                hit[bhc_pkg::RD_LEN_HOLD_CHECK] = ar.len != ar_q.len;
                hit[bhc_pkg::RD_SIZE_HOLD_CHECK] = ar.size != ar_q.size;
                hit[bhc_pkg::RD_QOS_HOLD_CHECK] = ar.qos != ar_q.qos;
            end
            hit[bhc_pkg::RD_REGION_HOLD_CHECK] = mode == bhc_pkg::BHC_AXI4 && ar.region != ar_q.region;
        end
        hit[bhc_pkg::RD_ADDR_VALID_HOLD_CHECK] = ar_drop;
        hit[bhc_pkg::RD_ADDR_READY_DELAY_ADVICE] = ar_slow;
        hit[bhc_pkg::RD_BEAT_COUNT_CHECK] = r_hs && hit_ok && not_lite
            && (r_end != (rd_left[hit_idx] == 9'h001));
        hit[bhc_pkg::RD_TAG_MATCH_CHECK] = (r_start | r_hs) & !hit_ok;
    end

    ////////////////////
    // Sticky flags; only the monitor reset clears them.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= 64'h0000_0000_0000_0000;
        end else begin
            status <= status | (hit & bhc_pkg::IMPL_MASK);
        end
    end
endmodule

//--- bhc_checker_assertions.sv
// Assertions on the violation flags of the bus handshake checker.
`timescale 1ns/1ps
////////////////////////
module bhc_checker_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic aresetn,
    input wire logic w_valid,
    input wire logic w_ready,
    input wire logic b_valid,
    input wire logic b_ready,
    input wire logic [1:0] b_resp,
    input wire logic ar_valid,
    input wire logic ar_ready,
    input wire bhc_pkg::bhc_ar_t ar,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [63:0] status
);
    logic [1:0] up;
    logic [1:0] mode;
    logic live;
    logic lite;
    assign live = up == 2'h3;
    assign lite = mode == bhc_pkg::BHC_LITE;
    // The design's reset copy lags, so nothing is promised before it settles.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            up <= 2'h0;
        end else if (!live) begin
            up <= up + 2'h1;
        end
    end
    // Mode shadow; read legality checks are skipped in Lite.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode <= bhc_pkg::MODE_RST;
        end else if (psel && penable && pwrite && paddr == {20'h0_0000, bhc_pkg::OFS_MODE} && pwdata[1:0] != 2'h3) begin
            mode <= pwdata[1:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!live);
    AST_WDATA_DROP: assert property (
        aresetn && w_valid && !w_ready ##1 aresetn && !w_valid |=> status[27]) else $error("w drop missed");
    AST_RESP_CODE_HOLD: assert property (
        aresetn && b_valid && !b_ready ##1 aresetn && b_valid && $changed(b_resp) |=> status[34])
        else $error("b code change missed");
    AST_RESP_DROP: assert property (
        aresetn && b_valid && !b_ready ##1 aresetn && !b_valid |=> status[35]) else $error("b drop missed");
    AST_RD_RSVD_BURST: assert property (
        aresetn && ar_valid && ar.burst == bhc_pkg::BURST_RSVD && !lite |=> status[39])
        else $error("reserved burst missed");
    AST_RD_CACHE: assert property (
        aresetn && ar_valid && !ar.cache[1] && ar.cache[3:2] != 2'b00 && !lite |=> status[41])
        else $error("cache combination missed");
    AST_RD_VALID_RESET: assert property (
        $rose(aresetn) && ar_valid |=> status[45]) else $error("ar valid after reset missed");
    AST_RD_ADDR_HOLD: assert property (
        aresetn && ar_valid && !ar_ready ##1 aresetn && ar_valid && $changed(ar.addr) |=> status[46])
        else $error("ar addr change missed");
    AST_RD_VALID_DROP: assert property (
        aresetn && ar_valid && !ar_ready ##1 aresetn && !ar_valid |=> status[56]) else $error("ar drop missed");
    AST_UNIMPL_CLEAR: assert property (
        !(status[30] || status[40] || status[51] || status[60])) else $error("unimplemented flag raised");
    AST_STICKY: assert property (
        (status & $past(status)) == $past(status)) else $error("flag cleared");
endmodule

bind bhc_checker bhc_checker_assertions u_bhc_checker_assertions (.clk(clk), .rst_b(rst_b), .aresetn(aresetn),
    .w_valid(w_valid), .w_ready(w_ready), .b_valid(b_valid), .b_ready(b_ready), .b_resp(b_resp),
    .ar_valid(ar_valid), .ar_ready(ar_ready), .ar(ar), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .status(status));

//--- bhc_checker_bench.sv
// Self-checking bench for the bus handshake checker.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
////////////////////////
module bhc_checker_bench;
    logic clk, rst_b, aresetn, aw_valid, aw_ready, w_valid, w_ready, w_last, b_valid, b_ready, ar_valid, ar_ready;
    logic r_valid, r_ready, r_last, psel, penable, pwrite, pready, pslverr, shrt;
    logic [3:0] b_id, r_id, lat;
    logic [1:0] b_resp;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [63:0] status;
    bhc_pkg::bhc_ar_t ar, base;
    bhc_pkg::bhc_ar_t tv[7];
    int tb[7] = '{39, 41, 42, 43, 38, 44, 37};
    int fo[10] = '{29, 16, 11, 61, 21, 15, 8, 18, 4, 0};
    int wb[5] = '{29, 33, 34, 35, 36};
    int failures = 0;
    int checks_done = 0;

    always #2 clk = ~clk;

    bhc_checker u_bhc_checker (.clk(clk), .rst_b(rst_b), .aresetn(aresetn), .aw_valid(aw_valid), .aw_ready(aw_ready),
        .w_valid(w_valid), .w_ready(w_ready), .w_last(w_last), .b_valid(b_valid), .b_ready(b_ready), .b_id(b_id),
        .b_resp(b_resp), .ar_valid(ar_valid), .ar_ready(ar_ready), .ar(ar), .r_valid(r_valid), .r_ready(r_ready),
        .r_id(r_id), .r_last(r_last), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .status(status));
    bhc_axi_pair u_bhc_axi_pair (.clk(clk), .aresetn(aresetn), .ar_valid(ar_valid), .ar(ar), .r_ready(r_ready),
        .lat(lat), .shrt(shrt), .ar_ready(ar_ready), .r_valid(r_valid), .r_id(r_id), .r_last(r_last));

    task summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bounded wait; a dead handshake ends the run.
    task automatic await(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== 1'b1 && n < 64);
        if (s !== 1'b1) begin
            failures++;
            summarize();
        end
    endtask
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        await(pready);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task bit_is(input int n, input logic e);
        apb(1'b0, (n < 32) ? 32'h0000_0008 : 32'h0000_000C, '0);
        `CHK("status bit", e, rd[n % 32])
    endtask
    task rd_req(input bhc_pkg::bhc_ar_t a);
        @(posedge clk);
        ar <= a;
        ar_valid <= 1'b1;
        await(ar_ready);
        ar_valid <= 1'b0;
        ar <= ~a;
        cyc(24);
    endtask
    function automatic bhc_pkg::bhc_ar_t mk(input logic [31:0] a, input logic [7:0] l, input logic [2:0] s,
        input logic [1:0] b, input logic [3:0] c);
        mk = '{id: 4'h3, addr: a, len: l, size: s, burst: b, lock: 1'b0, cache: c, prot: 3'h0, qos: 4'h0, region: 4'h0};
    endfunction

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        aresetn = 1'b0;
        r_ready = 1'b1;
        {aw_valid, aw_ready, w_valid, w_ready, w_last, b_valid, b_ready, ar_valid, psel, penable, pwrite, shrt} = '0;
        {b_id, b_resp, lat, paddr, pwdata} = '0;
        ar = '0;
        base = mk(32'h0000_0100, 8'h01, 3'h2, 2'b01, 4'h0);
        tv = '{mk(32'h0000_0000, 8'h00, 3'h2, 2'b11, 4'h0), mk(32'h0000_0000, 8'h00, 3'h2, 2'b01, 4'h4),
            mk(32'h0000_0000, 8'h10, 3'h2, 2'b00, 4'h0), mk(32'h0000_0000, 8'h02, 3'h2, 2'b10, 4'h0),
            mk(32'h0000_0102, 8'h01, 3'h2, 2'b10, 4'h0), mk(32'h0000_0000, 8'h00, 3'h3, 2'b01, 4'h0),
            mk(32'h0000_0FF0, 8'h07, 3'h2, 2'b01, 4'h0)};
        cyc(5);
        {rst_b, aresetn} <= 2'b11;
        cyc(3);
        apb(1'b0, 32'h0000_0000, '0);
        `CHK("wait reset", {16'h0000, bhc_pkg::WAIT_RST}, rd)
        apb(1'b0, 32'h0000_0010, '0);
        `CHK("unmapped", 1'b1, pslverr)
        for (int m = 1; m < 5; m++) begin
            apb(1'b1, 32'h0000_0004, 32'(m % 4));
            apb(1'b0, 32'h0000_0004, '0);
            `CHK("mode", (m == 3) ? 32'h0000_0002 : 32'(m % 4), rd)
        end
        apb(1'b1, 32'h0000_0000, 32'h0000_0004);
        apb(1'b1, 32'h0000_0008, 32'hFFFF_FFFF);
        $display("registers done");
        rd_req(base);
        apb(1'b0, 32'h0000_0008, '0);
        `CHK("status low", 32'h0000_0000, rd)
        apb(1'b0, 32'h0000_000C, '0);
        `CHK("status high", 32'h0000_0000, rd)
        lat <= 4'h6;
        rd_req(base);
        lat <= 4'h0;
        bit_is(57, 1'b1);
        shrt <= 1'b1;
        rd_req(base);
        shrt <= 1'b0;
        bit_is(58, 1'b1);
        $display("read timing done");
        for (int i = 0; i < 7; i++) begin
            bit_is(tb[i], 1'b0);
            rd_req(tv[i]);
            bit_is(tb[i], 1'b1);
        end
        $display("read legality done");
        lat <= 4'hF;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            ar <= base;
            ar_valid <= 1'b1;
            cyc(2);
            ar <= bhc_pkg::bhc_ar_t'(base ^ (65'h1 << fo[i]));
            cyc(2);
            ar_valid <= 1'b0;
            bit_is(46 + i, i != 5);
        end
        lat <= 4'h0;
        bit_is(56, 1'b1);
        $display("read hold done");
        @(posedge clk);
        w_valid <= 1'b1;
        cyc(6);
        w_valid <= 1'b0;
        bit_is(27, 1'b1);
        bit_is(28, 1'b1);
        aw_valid <= 1'b1;
        aw_ready <= 1'b1;
        @(posedge clk);
        {aw_valid, aw_ready, b_valid} <= 3'b001;
        cyc(2);
        b_id <= 4'h5;
        cyc(2);
        b_resp <= 2'h2;
        cyc(4);
        b_valid <= 1'b0;
        for (int k = 0; k < 5; k++) bit_is(wb[k], 1'b1);
        bit_is(32, 1'b0);
        $display("write side done");
        aresetn <= 1'b0;
        cyc(2);
        {aresetn, ar_valid, b_valid} <= 3'b111;
        @(posedge clk);
        {ar_valid, b_valid} <= 2'b00;
        bit_is(31, 1'b1);
        bit_is(45, 1'b1);
        bit_is(32, 1'b1);
        apb(1'b0, 32'h0000_0008, '0);
        `CHK("final low", 32'hB800_0000, rd)
        apb(1'b0, 32'h0000_000C, '0);
        `CHK("final high", 32'h07F7_FEFF, rd)
        $display("reset and sticky done");
        summarize();
    end
endmodule

//--- bhc_pkg.sv
// Shared constants and carriers of the bus handshake checker.
package bhc_pkg;

    localparam int ADDR_W = 32;
    localparam int ID_W = 4;

    // Register byte offsets.
    localparam logic [11:0] OFS_WAIT = 12'h000;
    localparam logic [11:0] OFS_MODE = 12'h004;
    localparam logic [11:0] OFS_STAT_LO = 12'h008;
    localparam logic [11:0] OFS_STAT_HI = 12'h00C;

    // Reset values.
    localparam logic [15:0] WAIT_RST = 16'h0010;

    // Protocol variant held in the mode register.
    typedef enum logic [1:0] {
        BHC_AXI4 = 2'b00,
        BHC_AXI3 = 2'b01,
        BHC_LITE = 2'b10
    } bhc_proto_t;

    localparam bhc_proto_t MODE_RST = BHC_AXI4;

    // Burst type encodings.
    localparam logic [1:0] BURST_FIXED = 2'b00;
    localparam logic [1:0] BURST_WRAP = 2'b10;
    localparam logic [1:0] BURST_RSVD = 2'b11;

    // Burst page limit in bytes.
    localparam logic [16:0] PAGE_BYTES = 17'h0_1000;
    localparam logic [7:0] FIXED_LEN_MAX = 8'h0F;

    // Positions of the violation flags in the status vector.
    localparam int WR_DATA_VALID_HOLD_CHECK = 27;
    localparam int WR_DATA_READY_DELAY_ADVICE = 28;
    localparam int RESP_BEFORE_LAST_BEAT_CHECK = 29;
    localparam int WR_EXCLUSIVE_OKAY_CHECK = 30;
    localparam int RESP_VALID_AFTER_RESET_CHECK = 31;
    localparam int RESP_BEFORE_ADDR_CHECK = 32;
    localparam int RESP_ID_HOLD_CHECK = 33;
    localparam int RESP_CODE_HOLD_CHECK = 34;
    localparam int RESP_VALID_HOLD_CHECK = 35;
    localparam int RESP_READY_DELAY_ADVICE = 36;
    localparam int RD_PAGE_CROSS_CHECK = 37;
    localparam int RD_WRAP_ALIGN_CHECK = 38;
    localparam int RD_BURST_RESERVED_CHECK = 39;
    localparam int RD_EXCLUSIVE_LEN_CHECK = 40;
    localparam int RD_CACHE_COMBO_CHECK = 41;
    localparam int RD_FIXED_LEN_CHECK = 42;
    localparam int RD_WRAP_LEN_CHECK = 43;
    localparam int RD_BEAT_WIDTH_CHECK = 44;
    localparam int RD_ADDR_VALID_AFTER_RESET_CHECK = 45;
    localparam int RD_ADDR_HOLD_CHECK = 46;
    localparam int RD_BURST_TYPE_HOLD_CHECK = 47;
    localparam int RD_CACHE_HOLD_CHECK = 48;
    localparam int RD_TAG_HOLD_CHECK = 49;
    localparam int RD_LEN_HOLD_CHECK = 50;
    localparam int RD_LOCK_HOLD_CHECK = 51;
    localparam int RD_PROT_HOLD_CHECK = 52;
    localparam int RD_SIZE_HOLD_CHECK = 53;
    localparam int RD_QOS_HOLD_CHECK = 54;
    localparam int RD_REGION_HOLD_CHECK = 55;
    localparam int RD_ADDR_VALID_HOLD_CHECK = 56;
    localparam int RD_ADDR_READY_DELAY_ADVICE = 57;
    localparam int RD_BEAT_COUNT_CHECK = 58;
    localparam int RD_TAG_MATCH_CHECK = 59;
    localparam int RD_EXCLUSIVE_OKAY_CHECK = 60;

    // Flags that may ever be raised; unimplemented checks stay clear.
    localparam logic [63:0] IMPL_MASK = 64'h0FF7_FEFF_B800_0000;

    // Read address channel payload.
    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [ADDR_W-1:0] addr;
        logic [7:0] len;
        logic [2:0] size;
        logic [1:0] burst;
        logic lock;
        logic [3:0] cache;
        logic [2:0] prot;
        logic [3:0] qos;
        logic [3:0] region;
    } bhc_ar_t;

endpackage
